/* File: verilog/acsc_consts.vh */
// register offsets, field positions and link timing constants
// assumes byte addressing on a 32-bit Avalon-MM slave
`ifndef ACSC_CONSTS_VH
`define ACSC_CONSTS_VH
`define ACSC_OFS_CTRL        8'h08
`define ACSC_OFS_RX_ASSIGN   8'h10
`define ACSC_OFS_TX_ASSIGN   8'h14
`define ACSC_OFS_A_RX_HOLD   8'h20
`define ACSC_OFS_A_TX_HOLD   8'h24
`define ACSC_OFS_A_STATUS    8'h28
`define ACSC_OFS_B_RX_HOLD   8'h30
`define ACSC_OFS_B_TX_HOLD   8'h34
`define ACSC_OFS_B_STATUS    8'h38
`define ACSC_OFS_CO_RX_HOLD  8'h40
`define ACSC_OFS_CO_TX_HOLD  8'h44
`define ACSC_OFS_CO_STATUS   8'h48
`define ACSC_CTRL_ENABLE     0
`define ACSC_CTRL_VRA        2
`define ACSC_ASSIGN_BITS     30
`define ACSC_SEL_NONE        3'h0
`define ACSC_SEL_A           3'h1
`define ACSC_SEL_B           3'h2
`define ACSC_ST_FREE         0
`define ACSC_ST_DRAINED      1
`define ACSC_ST_UNDERRUN     2
`define ACSC_ST_RX_FULL      4
`define ACSC_ST_OVERRUN      5
`define ACSC_ST_TX_DONE      10
`define ACSC_ST_TX_EXH       11
`define ACSC_ST_RX_DONE      14
`define ACSC_ST_RX_EXH       15
`define ACSC_CO_READ         23
`define ACSC_SLOT_BITS       20
`define ACSC_TAG_LAST        5'h0F
`define ACSC_DATA_LAST       5'h13
`define ACSC_LAST_SLOT       4'hC
`define ACSC_FIRST_DATA      4'h3
`endif

/* File: verilog/acsc_slot_channel.v */
// slot routing, holding registers and channel flags of an ac-link
// controller; codec bit clock and serial input come from another
// domain, registers sit on an avalon-mm slave clocked by ref_clk
`timescale 1ns/1ps
`include "acsc_consts.vh"

// How it works
// - input slot selector: drop, channel A, B
// - output slot selector: none, channel A, B
// - codec slot 2 status into rx hold
// - slot 1 carries read/write direction flag
// - slot 1 carries codec register index
// - slot 2 carries 16-bit command word
// - channel sample in low 20 bits
// - channel transmit from low 20 bits
// - free flag low while holding occupied
// - drained only after shift completes
// - underrun in variable rate, read clears
// - rx full set on load, rx hold read clears
// - overrun on unread reload, read clears
// - fixed rate unless codec paces slots
// - every data slot 20 bits wide
// - channel A receive count flags
// - channel A transmit count flags
module acsc_slot_channel
(
	input  wire        ref_clk,
	input  wire        srst,
	input  wire        ce,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        bit_clk,
	input  wire        codec_status_word_in,
	output reg         sync,
	output reg         codec_status_word_out,
	input  wire        a_rx_count_zero,
	input  wire        a_rx_next_zero,
	input  wire        a_tx_count_zero,
	input  wire        a_tx_next_zero
);
	reg         ack;
	reg  [31:0] ctrl;
	reg  [29:0] rx_assign;
	reg  [29:0] tx_assign;
	reg  [19:0] tx_hold_a;
	reg  [19:0] tx_hold_b;
	reg  [19:0] rx_hold_a;
	reg  [19:0] rx_hold_b;
	reg  [23:0] cmd_hold;
	reg  [23:0] cmd_shift;
	reg         cmd_out_valid;
	reg  [15:0] codec_status_word;
	reg  [2:0]  clk_sync;
	reg  [1:0]  din_sync;
	reg  [3:0]  slot_idx;
	reg  [4:0]  slot_bit;
	reg  [3:0]  drv_slot;
	reg  [4:0]  drv_bit;
	reg  [18:0] out_shift;
	reg  [18:0] in_shift;
	reg  [15:0] in_tag;
	reg  [9:0]  slot_req;
	reg  [19:0] slot_word;
	wire        acc;
	wire        rise;
	wire        fall;
	wire        link_en;
	wire        variable_rate_enable;
	wire        slot_start;
	wire        slot_end;
	wire        in_end;
	wire [4:0]  out_base;
	wire [4:0]  in_base;
	wire [2:0]  out_sel;
	wire [2:0]  in_sel;
	wire [15:0] tag_out;
	wire [19:0] in_word;
	wire        out_slot_on;
	wire        in_slot_on;
	wire [2:0]  wr_tx;
	wire [2:0]  rd_rx;
	wire [2:0]  rd_st;
	wire [2:0]  tx_load;
	wire [2:0]  busy_clr;
	wire [2:0]  rx_load;
	wire [2:0]  ur_evt;
	wire [2:0]  hold_full;
	wire [2:0]  shift_busy;
	wire [2:0]  rx_full;
	wire [2:0]  overrun;
	wire [2:0]  underrun;
	wire [31:0] stat_a;
	wire [31:0] stat_b;
	wire [31:0] stat_co;

	// one wait cycle, then the answer; side effects at that edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign acc = ack & ~avs_waitrequest;
	assign link_en = ctrl[`ACSC_CTRL_ENABLE];
	assign variable_rate_enable = ctrl[`ACSC_CTRL_VRA];

	always @(posedge ref_clk)
	begin
		if (srst)
			ack <= 1'b0;
		else if (ce)
			ack <= (avs_read | avs_write) & ~ack;
	end

	// the first stage feeds only the second
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			clk_sync <= 3'h0;
			din_sync <= 2'h0;
		end
		else if (ce)
		begin
			clk_sync <= {clk_sync[1:0], bit_clk};
			din_sync <= {din_sync[0], codec_status_word_in};
		end
	end

	assign rise = clk_sync[1] & ~clk_sync[2];
	assign fall = ~clk_sync[1] & clk_sync[2];

	// register writes
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			ctrl <= 32'h00000000;
			rx_assign <= 30'h00000000;
			tx_assign <= 30'h00000000;
			tx_hold_a <= 20'h00000;
			tx_hold_b <= 20'h00000;
			cmd_hold <= 24'h000000;
		end
		else if (ce && acc && avs_write)
		begin
			case (avs_address)
			`ACSC_OFS_CTRL:
				ctrl <= {29'h00000000, avs_writedata[2:0]};
			`ACSC_OFS_RX_ASSIGN:
				rx_assign <= avs_writedata[29:0];
			`ACSC_OFS_TX_ASSIGN:
				tx_assign <= avs_writedata[29:0];
			`ACSC_OFS_A_TX_HOLD:
				tx_hold_a <= avs_writedata[19:0];
			`ACSC_OFS_B_TX_HOLD:
				tx_hold_b <= avs_writedata[19:0];
			`ACSC_OFS_CO_TX_HOLD:
				cmd_hold <= avs_writedata[23:0];
			default:
				cmd_hold <= cmd_hold;
			endcase
		end
	end

	assign wr_tx[0] = acc & avs_write & (avs_address == `ACSC_OFS_A_TX_HOLD);
	assign wr_tx[1] = acc & avs_write & (avs_address == `ACSC_OFS_B_TX_HOLD);
	assign wr_tx[2] = acc & avs_write & (avs_address == `ACSC_OFS_CO_TX_HOLD);
	assign rd_rx[0] = acc & avs_read & (avs_address == `ACSC_OFS_A_RX_HOLD);
	assign rd_rx[1] = acc & avs_read & (avs_address == `ACSC_OFS_B_RX_HOLD);
	assign rd_rx[2] = acc & avs_read & (avs_address == `ACSC_OFS_CO_RX_HOLD);
	assign rd_st[0] = acc & avs_read & (avs_address == `ACSC_OFS_A_STATUS);
	assign rd_st[1] = acc & avs_read & (avs_address == `ACSC_OFS_B_STATUS);
	assign rd_st[2] = acc & avs_read & (avs_address == `ACSC_OFS_CO_STATUS);

	// count flags follow the transfer counters live
	assign stat_a = {16'h0000, a_rx_next_zero & a_rx_count_zero,
		a_rx_count_zero, 2'h0, a_tx_next_zero & a_tx_count_zero,
		a_tx_count_zero, 4'h0, overrun[0], rx_full[0], 1'b0,
		underrun[0], ~hold_full[0] & ~shift_busy[0], ~hold_full[0]};
	assign stat_b = {26'h0000000, overrun[1], rx_full[1], 1'b0,
		underrun[1], ~hold_full[1] & ~shift_busy[1], ~hold_full[1]};
	assign stat_co = {26'h0000000, overrun[2], rx_full[2], 1'b0,
		underrun[2], ~hold_full[2] & ~shift_busy[2], ~hold_full[2]};

	// read data registered at the edge that ends the wait cycle
	always @(posedge ref_clk)
	begin
		if (srst)
			avs_readdata <= 32'h00000000;
		else if (ce && avs_read && !ack)
		begin
			case (avs_address)
			`ACSC_OFS_CTRL:       avs_readdata <= ctrl;
			`ACSC_OFS_RX_ASSIGN:  avs_readdata <= {2'h0, rx_assign};
			`ACSC_OFS_TX_ASSIGN:  avs_readdata <= {2'h0, tx_assign};
			`ACSC_OFS_A_RX_HOLD:  avs_readdata <= {12'h000, rx_hold_a};
			`ACSC_OFS_B_RX_HOLD:  avs_readdata <= {12'h000, rx_hold_b};
			`ACSC_OFS_A_STATUS:   avs_readdata <= stat_a;
			`ACSC_OFS_B_STATUS:   avs_readdata <= stat_b;
			`ACSC_OFS_CO_RX_HOLD:
				avs_readdata <= {16'h0000, codec_status_word};
			`ACSC_OFS_CO_STATUS:  avs_readdata <= stat_co;
			default:              avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// link framing: slot 0 is 16 bits, slots 1..12 are 20 bits
	assign slot_start = rise & (slot_bit == 5'h00);
	assign slot_end = (slot_idx == 4'h0) ? (slot_bit == `ACSC_TAG_LAST)
		: (slot_bit == `ACSC_DATA_LAST);
	assign out_base = {1'b0, slot_idx - `ACSC_FIRST_DATA} * 5'd3;
	assign out_sel = tx_assign[out_base +: 3];
	assign in_base = {1'b0, drv_slot - `ACSC_FIRST_DATA} * 5'd3;
	assign in_sel = rx_assign[in_base +: 3];
	// codec paces slots only in variable rate mode
	assign out_slot_on = (out_sel != `ACSC_SEL_NONE) &
		(~variable_rate_enable | slot_req[slot_idx - `ACSC_FIRST_DATA]);

	genvar s;
	generate
		for (s = 3; s <= 12; s = s + 1)
		begin : g_tag
			wire [2:0] sel_o = tx_assign[3*(s-3) +: 3];
			assign tag_out[15-s] = (sel_o != `ACSC_SEL_NONE) &
				(~variable_rate_enable | slot_req[s-3]);
		end
	endgenerate
	assign tag_out[15] = 1'b1;
	assign tag_out[14] = hold_full[2];
	assign tag_out[13] = hold_full[2];
	assign tag_out[2:0] = 3'h0;

	always @*
	begin
		slot_word = 20'h00000;
		case (slot_idx)
		4'h0: slot_word = {tag_out, 4'h0};
		4'h1:
			if (cmd_out_valid)
				slot_word = {cmd_shift[`ACSC_CO_READ], cmd_shift[22:16],
					12'h000};
		4'h2:
			if (cmd_out_valid)
				slot_word = {cmd_shift[15:0], 4'h0};
		default:
			if (out_slot_on && out_sel == `ACSC_SEL_A && hold_full[0])
				slot_word = tx_hold_a;
			else if (out_slot_on && out_sel == `ACSC_SEL_B && hold_full[1])
				slot_word = tx_hold_b;
		endcase
	end

	// data slot takes the holding word only when it really goes out
	assign tx_load[0] = slot_start & (slot_idx >= `ACSC_FIRST_DATA) &
		out_slot_on & (out_sel == `ACSC_SEL_A) & hold_full[0];
	assign tx_load[1] = slot_start & (slot_idx >= `ACSC_FIRST_DATA) &
		out_slot_on & (out_sel == `ACSC_SEL_B) & hold_full[1];
	assign tx_load[2] = slot_start & (slot_idx == 4'h0) & hold_full[2];
	assign busy_clr[0] = slot_start;
	assign busy_clr[1] = slot_start;
	assign busy_clr[2] = slot_start & (slot_idx == `ACSC_FIRST_DATA);
	assign ur_evt[0] = slot_start & variable_rate_enable & (slot_idx >= `ACSC_FIRST_DATA)
		& out_slot_on & (out_sel == `ACSC_SEL_A) & ~hold_full[0];
	assign ur_evt[1] = slot_start & variable_rate_enable & (slot_idx >= `ACSC_FIRST_DATA)
		& out_slot_on & (out_sel == `ACSC_SEL_B) & ~hold_full[1];
	assign ur_evt[2] = 1'b0;

	// transmit side, driven after each bit clock rise
	always @(posedge ref_clk)
	begin
		if (srst || (ce && !link_en))
		begin
			slot_idx <= 4'h0;
			slot_bit <= 5'h00;
			drv_slot <= 4'h0;
			drv_bit <= 5'h00;
			out_shift <= 19'h00000;
			sync <= 1'b0;
			codec_status_word_out <= 1'b0;
			cmd_shift <= 24'h000000;
			cmd_out_valid <= 1'b0;
		end
		else if (ce && rise)
		begin
			drv_slot <= slot_idx;
			drv_bit <= slot_bit;
			sync <= (slot_idx == 4'h0);
			if (slot_bit == 5'h00)
			begin
				codec_status_word_out <= slot_word[19];
				out_shift <= slot_word[18:0];
			end
			else
			begin
				codec_status_word_out <= out_shift[18];
				out_shift <= {out_shift[17:0], 1'b0};
			end
			if (tx_load[2])
				cmd_shift <= cmd_hold;
			if (slot_start && slot_idx == 4'h0)
				cmd_out_valid <= hold_full[2];
			if (slot_end)
			begin
				slot_bit <= 5'h00;
				slot_idx <= (slot_idx == `ACSC_LAST_SLOT) ? 4'h0
					: slot_idx + 4'h1;
			end
			else
				slot_bit <= slot_bit + 5'h01;
		end
	end

	// receive side, sampled at each bit clock fall
	assign in_word = {in_shift, din_sync[1]};
	assign in_end = fall & ((drv_slot == 4'h0) ?
		(drv_bit == `ACSC_TAG_LAST) : (drv_bit == `ACSC_DATA_LAST));
	assign in_slot_on = in_tag[15 - drv_slot];
	assign rx_load[0] = in_end & (drv_slot >= `ACSC_FIRST_DATA) &
		in_slot_on & (in_sel == `ACSC_SEL_A);
	assign rx_load[1] = in_end & (drv_slot >= `ACSC_FIRST_DATA) &
		in_slot_on & (in_sel == `ACSC_SEL_B);
	assign rx_load[2] = in_end & (drv_slot == 4'h2) & in_tag[13];

	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			in_shift <= 19'h00000;
			in_tag <= 16'h0000;
			slot_req <= 10'h000;
			rx_hold_a <= 20'h00000;
			rx_hold_b <= 20'h00000;
			codec_status_word <= 16'h0000;
		end
		else if (ce && fall && link_en)
		begin
			in_shift <= in_word[18:0];
			if (in_end && drv_slot == 4'h0)
				in_tag <= in_word[15:0];
			// request bits are active low in input slot 1
			if (in_end && drv_slot == 4'h1 && in_tag[14])
				slot_req <= ~in_word[11:2];
			if (rx_load[0])
				rx_hold_a <= in_word;
			if (rx_load[1])
				rx_hold_b <= in_word;
			if (rx_load[2])
				codec_status_word <= in_word[19:4];
		end
	end

	// per-channel flags: 0 is A, 1 is B, 2 the codec channel;
	// every hardware set wins over a clear in the same cycle
	genvar c;
	generate
		for (c = 0; c < 3; c = c + 1)
		begin : g_chan
			reg full_r;
			reg busy_r;
			reg rxf_r;
			reg ovr_r;
			reg udr_r;
			wire ld_rx = rx_load[c] & ce & fall & link_en;
			wire ld_tx = tx_load[c] & ce & rise & link_en;
			always @(posedge ref_clk)
			begin
				if (srst)
				begin
					full_r <= 1'b0;
					busy_r <= 1'b0;
					rxf_r <= 1'b0;
					ovr_r <= 1'b0;
					udr_r <= 1'b0;
				end
				else if (ce)
				begin
					if (wr_tx[c])
						full_r <= 1'b1;
					else if (ld_tx)
						full_r <= 1'b0;
					if (ld_tx)
						busy_r <= 1'b1;
					else if (busy_clr[c] & rise & link_en)
						busy_r <= 1'b0;
					else if (!link_en)
						busy_r <= 1'b0;
					if (ld_rx)
						rxf_r <= 1'b1;
					else if (rd_rx[c])
						rxf_r <= 1'b0;
					if (ld_rx & rxf_r & ~rd_rx[c])
						ovr_r <= 1'b1;
					else if (rd_st[c])
						ovr_r <= 1'b0;
					if (ur_evt[c] & rise & link_en)
						udr_r <= 1'b1;
					else if (rd_st[c])
						udr_r <= 1'b0;
				end
			end
			assign hold_full[c] = full_r;
			assign shift_busy[c] = busy_r;
			assign rx_full[c] = rxf_r;
			assign overrun[c] = ovr_r;
			assign underrun[c] = udr_r;
		end
	endgenerate

endmodule // acsc_slot_channel

/* File: sim/acsc_monitor.sv */
// port checker for acsc_slot_channel
// assumes ref_clk at 50 ns, link bit clock at 400 ns
`timescale 1ns/1ps
module acsc_monitor
(
	input wire        ref_clk,
	input wire        srst,
	input wire        ce,
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        bit_clk,
	input wire        sync,
	input wire        codec_status_word_out,
	input wire        a_rx_count_zero,
	input wire        a_rx_next_zero,
	input wire        a_tx_count_zero,
	input wire        a_tx_next_zero
);
	reg  [11:0] fcnt;
	reg  [3:0]  bcnt;
	reg         bc_d;
	reg         sy_d;
	wire        rdn = avs_read & ~avs_waitrequest;
	// saturating, so a stopped link never wraps into a pass
	always @(posedge ref_clk)
	begin
		bc_d <= bit_clk;
		sy_d <= sync;
		if (srst)
			bcnt <= 4'hF;
		else if (bit_clk & ~bc_d)
			bcnt <= 4'h0;
		else if (bcnt != 4'hF)
			bcnt <= bcnt + 4'h1;
		if (srst)
			fcnt <= 12'hFFF;
		else if (sync & ~sy_d)
			fcnt <= 12'h000;
		else if (fcnt != 12'hFFF)
			fcnt <= fcnt + 12'h001;
	end
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (srst || !ce);
	chk_frame_len: assert property ($rose(sync) && fcnt != 12'hFFF
		|-> fcnt >= 12'd2045 && fcnt <= 12'd2049) else $error("frame len");
	chk_bit_edge: assert property ($changed(codec_status_word_out) || $changed(sync)
		|-> bcnt >= 4'h1 && bcnt <= 4'h6) else $error("link timing");
	// a frozen ack holds waitrequest, so count only running cycles
	chk_one_wait: assert property (ce && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait length");
	chk_assign_rsvd: assert property (rdn && avs_address[7:3] == 5'h02
		|-> avs_readdata[31:30] == 2'h0) else $error("assign rsvd");
	chk_rx_upper: assert property (rdn && (avs_address == 8'h20
		|| avs_address == 8'h30) |-> avs_readdata[31:20] == 12'h000)
		else $error("rx upper");
	chk_co_upper: assert property (rdn && avs_address == 8'h40
		|-> avs_readdata[31:16] == 16'h0000) else $error("codec upper");
	chk_stat_rsvd: assert property (rdn && avs_address[3:0] == 4'h8
		&& avs_address[7:4] != 4'h2 && avs_address[7:4] != 4'h0
		|-> (avs_readdata & 32'hFFFFFFC8) == 32'h0) else $error("stat rsvd");
	chk_rx_counts: assert property (rdn && avs_address == 8'h28
		|-> avs_readdata[15:14] == {$past(a_rx_count_zero)
		& $past(a_rx_next_zero), $past(a_rx_count_zero)}) else $error("rx cnt");
	chk_tx_counts: assert property (rdn && avs_address == 8'h28
		|-> avs_readdata[11:10] == {$past(a_tx_count_zero)
		& $past(a_tx_next_zero), $past(a_tx_count_zero)}) else $error("tx cnt");
endmodule // acsc_monitor
bind acsc_slot_channel acsc_monitor chk
(
	.ref_clk(ref_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
	.avs_read(avs_read), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .bit_clk(bit_clk), .sync(sync),
	.codec_status_word_out(codec_status_word_out), .a_rx_count_zero(a_rx_count_zero),
	.a_rx_next_zero(a_rx_next_zero), .a_tx_count_zero(a_tx_count_zero),
	.a_tx_next_zero(a_tx_next_zero)
);

/* File: sim/acsc_codec_model.sv */
// codec stand-in: bit clock, plays in_frame, records output frames
// assumes sync rises with output bit 0 of each frame
`timescale 1ns/1ps
module acsc_codec_model
(
	input  wire         run,
	input  wire         sync,
	input  wire         codec_status_word_out,
	input  wire [255:0] in_frame,
	output reg          bit_clk,
	output reg          codec_status_word_in,
	output reg  [255:0] out_frame,
	output reg  [15:0]  frames
);
	reg [255:0] cap;
	reg [7:0]   pos;
	reg         sy_d;
	wire        sof = sync & ~sy_d;
	initial
	begin
		bit_clk = 0;
		codec_status_word_in = 0;
		out_frame = 0;
		frames = 0;
		pos = 0;
		sy_d = 0;
		#7;
		forever #200 bit_clk = run ? ~bit_clk : 1'b0;
	end
	// bit 0 leaves before sync is seen, so the first frame is rough
	always @(posedge bit_clk)
		codec_status_word_in <= in_frame[255 - pos];
	always @(negedge bit_clk)
	begin
		if (sof)
		begin
			out_frame <= cap;
			frames <= frames + 16'h1;
		end
		pos <= sof ? 8'h1 : pos + 8'h1;
		cap[sof ? 255 : 255 - pos] <= codec_status_word_out;
		sy_d <= sync;
	end
endmodule // acsc_codec_model

/* File: sim/acsc_slot_channel_tb.sv */
// self-checking bench for acsc_slot_channel
// assumes the codec model on the link and the bound monitor
`timescale 1ns/1ps
module acsc_slot_channel_tb;
	reg          ref_clk, srst, ce, avs_read, avs_write, run;
	reg  [7:0]   avs_address;
	reg  [31:0]  avs_writedata, rd, w, ra, rb;
	reg  [3:0]   cnt_in;
	reg  [255:0] in_frame;
	wire [31:0]  avs_readdata;
	wire         avs_waitrequest, bit_clk, codec_status_word_in, sync, codec_status_word_out;
	wire [255:0] out_frame;
	wire [15:0]  frames;
	integer      miscompares, tests_run, cyc, i;
	acsc_slot_channel uut
	(
		.ref_clk(ref_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.bit_clk(bit_clk), .codec_status_word_in(codec_status_word_in), .sync(sync),
		.codec_status_word_out(codec_status_word_out), .a_rx_count_zero(cnt_in[0]),
		.a_rx_next_zero(cnt_in[1]), .a_tx_count_zero(cnt_in[2]),
		.a_tx_next_zero(cnt_in[3])
	);
	acsc_codec_model codec
	(
		.run(run), .sync(sync), .codec_status_word_out(codec_status_word_out), .in_frame(in_frame),
		.bit_clk(bit_clk), .codec_status_word_in(codec_status_word_in), .out_frame(out_frame),
		.frames(frames)
	);
	function [19:0] sl(input [255:0] f, input integer n);
		sl = f[239 - 20 * (n - 1) -: 20];
	endfunction
	function [3:0] cnt_exp(input [3:0] c);
		cnt_exp = {c[1] & c[0], c[0], c[3] & c[2], c[2]};
	endfunction
	task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp)
			begin
				miscompares = miscompares + 1;
				$display("unexpected %0s: expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task bus(input wr, input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_read <= ~wr;
			avs_write <= wr;
			@(posedge ref_clk);
			while (avs_waitrequest !== 1'b0)
				@(posedge ref_clk);
			rd = avs_readdata;
			avs_read <= 0;
			avs_write <= 0;
		end
	endtask
	task frm(input integer n);
		integer t;
		begin
			t = frames + n;
			while (frames < t)
				@(posedge ref_clk);
		end
	endtask
	// park mid slot 1, far from any slot 3 load or move
	task sync_mid;
		begin
			@(negedge sync);
			repeat (100) @(posedge ref_clk);
		end
	endtask
	task final_report;
		begin
			$display("tests_run %0d miscompares %0d", tests_run, miscompares);
			if (miscompares == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial
	begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			miscompares = miscompares + 1;
			final_report;
		end
	end
	initial
	begin
		srst = 1;
		ce = 1;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		run = 0;
		cnt_in = 0;
		in_frame = 0;
		miscompares = 0;
		tests_run = 0;
		cyc = 0;
		w = $urandom(32'h3A32);
		repeat (16) @(posedge ref_clk);
		srst <= 0;
		run <= 1;
		bus(0, 8'h10, 0);
		check("rx_asgn", rd, 0);
		for (i = 0; i < 2; i = i + 1)
		begin
			w = $urandom;
			bus(1, i ? 8'h14 : 8'h10, w);
			bus(0, i ? 8'h14 : 8'h10, 0);
			check("assign", rd, w & 32'h3FFFFFFF);
		end
		bus(0, 8'h0C, 0);
		check("unmapped", rd, 0);
		bus(0, 8'h24, 0);
		check("wo_read", rd, 0);
		bus(0, 8'h28, 0);
		check("a_rx_rdy", rd[4], 0);
		// clock enable low must hold off the answer and the write
		ce <= 0;
		fork
			bus(1, 8'h10, 32'h5);
			begin
				repeat (6) @(posedge ref_clk);
				check("ce_wait", avs_waitrequest, 1);
				ce <= 1;
			end
		join
		bus(0, 8'h10, 0);
		check("ce_write", rd, 32'h5);
		$display("test regs done");
		bus(1, 8'h08, 1);
		bus(1, 8'h14, 32'h11);
		frm(1);
		sync_mid;
		ra = $urandom;
		rb = $urandom;
		w = $urandom & 32'hFFFFFF;
		bus(1, 8'h24, ra);
		bus(1, 8'h34, rb);
		bus(1, 8'h44, w);
		bus(0, 8'h28, 0);
		check("a_tx_flg", rd[1:0], 0);
		frm(1);
		check("slot3", sl(out_frame, 3), ra[19:0]);
		check("slot4", sl(out_frame, 4), rb[19:0]);
		check("tags", out_frame[252:250], 3'h6);
		frm(1);
		check("slot1", sl(out_frame, 1), {w[23:16], 12'h0});
		check("slot2", sl(out_frame, 2), {w[15:0], 4'h0});
		bus(0, 8'h28, 0);
		check("a_tx_flg", rd[2:0], 3);
		bus(0, 8'h38, 0);
		check("b_tx_flg", rd[2:0], 3);
		$display("test transmit done");
		bus(1, 8'h10, 32'h81);
		ra = $urandom;
		rb = $urandom;
		w = $urandom;
		in_frame <= {16'hFFF8, 20'h0, w[15:0], 4'h0, ra[19:0], ~ra[19:0],
			rb[19:0], ~rb[19:0], 120'h0};
		frm(3);
		sync_mid;
		bus(0, 8'h28, 0);
		check("a_rx_flg", rd[5:4], 3);
		bus(0, 8'h20, 0);
		check("a_rx", rd, {12'h0, ra[19:0]});
		bus(0, 8'h30, 0);
		check("b_rx", rd, {12'h0, rb[19:0]});
		bus(0, 8'h40, 0);
		check("co_rx", rd, {16'h0, w[15:0]});
		bus(0, 8'h28, 0);
		check("a_rx_flg", rd[5:4], 0);
		frm(1);
		bus(0, 8'h28, 0);
		check("a_rx_flg", rd[5:4], 1);
		$display("test receive done");
		bus(1, 8'h08, 5);
		frm(2);
		sync_mid;
		bus(0, 8'h28, 0);
		check("a_tx_underrun", rd[2], 1);
		bus(0, 8'h28, 0);
		check("a_tx_underrun", rd[2], 0);
		$display("test underrun done");
		for (i = 0; i < 8; i = i + 1)
		begin
			cnt_in <= $urandom;
			bus(0, 8'h28, 0);
			check("a_cnt", {rd[15:14], rd[11:10]}, cnt_exp(cnt_in));
		end
		$display("test counts done");
		final_report;
	end
endmodule // acsc_slot_channel_tb
